// ==== verilog/e1_framing_timing_config.sv ====
// Purpose: E1 network framer, transmit timing and map exchange.
// Assumes: Line and port strobes are synchronous one-cycle pulses.
// Notes: Registers over AHB-Lite, zero wait states, always OKAY.
`timescale 1ns/100ps
`include "e1_map.svh"

module e1_framing_timing_config
  import e1_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `E1_SEC_CYCLES,
  parameter logic [7:0] INT_DIV = 8'(`E1_INT_DIV)
) (
  input wire logic hclk, // Bus and core clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word only, not checked
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic rx_tick, // Byte recovered from line
  input wire logic [7:0] rx_byte, // Received byte
  input wire logic drop_clk_tick, // Drop port recovered byte clock
  input wire logic dte_clk_tick, // DTE clock byte strobe
  input wire logic sec_present, // Secondary module fitted
  input wire logic [7:0] drop_tx_byte, // Drop byte for tx_slot
  input wire logic [7:0] dte_tx_byte, // DTE byte for tx_slot
  input wire logic [7:0] drop_sig, // ABCD for tx_frame, tx_frame+16
  output logic tx_tick, // Selected transmit byte strobe
  output logic [7:0] tx_byte, // Transmit byte
  output logic tx_valid, // tx_byte fresh
  output logic [4:0] tx_slot, // Slot being built
  output logic [3:0] tx_frame, // Frame in multiframe
  output rx_out_type rx_out, // Routed receive byte
  output logic frame_sync, // Receive in sync
  output logic far_alarm // Remote alarm being sent
);
  state_type q, d;
  logic sec_tick, int_tick, take, alarm_tx, crc_hit, fas_ok, even0;
  logic [63:0] act;
  logic [1:0] rcode, tcode;
  logic [7:0] tb, cb;
  tod_type tod_n;
  logic [31:0] rd;
  // Literals cannot be bit-selected, so the Si word gets a name
  localparam logic [15:0] SI_BITS = `E1_SI_PATTERN;

  // Bitwise CRC-4, polynomial x^4+x+1
  function automatic logic [3:0] crc4(input logic [3:0] c,
                                      input logic [7:0] b);
    logic [3:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[3] ^ b[i];
      r = {r[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
    end
    return r;
  endfunction

  // Transmit clock selection; receive side always runs on rx_tick
  always_comb begin
    unique case (q.ctrl.timing)
      TM_NET, TM_NORMAL: tx_tick = rx_tick;
      TM_DROP: tx_tick = drop_clk_tick;
      TM_DTE: tx_tick = dte_clk_tick;
      TM_INT: tx_tick = int_tick;
      default: tx_tick = 1'b0;
    endcase
  end

  // Shared decode terms
  assign sec_tick = q.sec_cnt == SEC_CYCLES - 1;
  assign int_tick = q.int_cnt == INT_DIV - 8'h01;
  assign take = hsel && htrans[1] && hready;
  assign act = q.ctrl.map_sel ? q.map_b : q.map_a;
  assign rcode = act[{q.rx_ts, 1'b0} +: 2];
  assign tcode = act[{q.tx_ts, 1'b0} +: 2];
  assign alarm_tx = q.ctrl.far_gen && q.fsm != SYNC;
  assign fas_ok = rx_byte[6:0] == `E1_FAS;
  assign even0 = q.rx_ts == 5'h00 && !q.rx_fr[0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign tx_byte = q.tx_byte;
  assign tx_valid = q.tx_valid;
  assign tx_slot = q.tx_ts;
  assign tx_frame = q.tx_fr;
  assign rx_out = q.rx_out;
  assign frame_sync = q.fsm == SYNC;
  assign far_alarm = alarm_tx;

  // Read mux, sampled in the address phase
  always_comb begin
    rd = `E1_REG_RST;
    unique case (haddr[11:0])
      `E1_CTRL_OFS: begin
        // Field by field; struct order is not the register layout
        rd[`E1_NFAS_BIT] = q.ctrl.nfas_en;
        rd[`E1_CAS_BIT] = q.ctrl.cas_en;
        rd[`E1_CRC_BIT] = q.ctrl.crc_en;
        rd[`E1_FARGEN_BIT] = q.ctrl.far_gen;
        rd[`E1_TIMING_LSB +: 3] = q.ctrl.timing;
        rd[`E1_XCHG_BIT] = q.ctrl.xchg_en;
        rd[`E1_MAPSEL_BIT] = q.ctrl.map_sel;
      end
      `E1_STAT_OFS: begin
        rd[`E1_SYNC_BIT] = q.fsm == SYNC;
        rd[`E1_CRCERR_BIT] = q.crc_err;
        rd[`E1_ALARM_BIT] = q.fsm != SYNC;
        rd[`E1_INUSE_BIT] = q.ctrl.map_sel;
      end
      `E1_TOD_OFS: rd[16:0] = q.tod;
      `E1_TIMEA_OFS: rd[16:0] = q.time_a;
      `E1_TIMEB_OFS: rd[16:0] = q.time_b;
      `E1_MAPA_LO_OFS: rd = q.map_a[31:0];
      `E1_MAPA_HI_OFS: rd = q.map_a[63:32];
      `E1_MAPB_LO_OFS: rd = q.map_b[31:0];
      `E1_MAPB_HI_OFS: rd = q.map_b[63:32];
      default: rd = `E1_REG_RST;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    d.tx_valid = 1'b0;
    d.rx_out.drop_valid = 1'b0;
    d.rx_out.dte_valid = 1'b0;
    crc_hit = 1'b0;
    tod_n = q.tod;
    tb = 8'hff;
    cb = 8'h00;
    // Bus address phase
    d.wr_pend = take && hwrite;
    if (take) begin
      d.addr = haddr[11:0];
      d.rdata = hwrite ? `E1_REG_RST : rd;
    end
    // Bus data phase write
    if (q.wr_pend) begin
      unique case (q.addr)
        `E1_CTRL_OFS: begin
          d.ctrl.nfas_en = hwdata[`E1_NFAS_BIT];
          d.ctrl.cas_en = hwdata[`E1_CAS_BIT];
          d.ctrl.crc_en = hwdata[`E1_CRC_BIT];
          d.ctrl.far_gen = hwdata[`E1_FARGEN_BIT];
          d.ctrl.xchg_en = hwdata[`E1_XCHG_BIT];
          d.ctrl.map_sel = hwdata[`E1_MAPSEL_BIT];
          // Unknown codes and normal without module are refused
          if (hwdata[6:4] <= 3'h4 && (hwdata[6:4] != 3'h4 || sec_present))
            d.ctrl.timing = timing_type'(hwdata[6:4]);
        end
        `E1_STAT_OFS: if (hwdata[`E1_CRCERR_BIT]) d.crc_err = 1'b0;
        `E1_TOD_OFS: d.tod = hwdata[16:0];
        `E1_TIMEA_OFS: d.time_a = hwdata[16:0];
        `E1_TIMEB_OFS: d.time_b = hwdata[16:0];
        `E1_MAPA_LO_OFS: d.map_a[31:0] = hwdata;
        `E1_MAPA_HI_OFS: d.map_a[63:32] = hwdata;
        `E1_MAPB_LO_OFS: d.map_b[31:0] = hwdata;
        `E1_MAPB_HI_OFS: d.map_b[63:32] = hwdata;
        default: ;
      endcase
    end
    // TS16 held idle in both maps while CAS is on
    if (q.ctrl.cas_en) begin
      d.map_a[33:32] = SL_IDLE;
      d.map_b[33:32] = SL_IDLE;
    end
    // Receive framer on line timing
    if (rx_tick) begin
      d.rx_ts = 5'(q.rx_ts + 5'h01);
      d.rx_fr = q.rx_ts == 5'h1f ? 4'(q.rx_fr + 4'h1) : q.rx_fr;
      unique case (q.fsm)
        HUNT: if (fas_ok) begin
          d.rx_ts = 5'h01;
          d.rx_fr = 4'h0;
          d.fsm = NFAS_CHK;
        end
        NFAS_CHK: if (q.rx_ts == 5'h00)
          d.fsm = (!q.ctrl.nfas_en || rx_byte[6]) ? FAS_CHK : HUNT;
        FAS_CHK: if (even0)
          d.fsm = !fas_ok ? HUNT : q.ctrl.cas_en ? MF_HUNT : SYNC;
        MF_HUNT: begin
          if (even0 && !fas_ok)
            d.fsm = HUNT;
          else if (q.rx_ts == `E1_TS16 && !q.rx_fr[0] &&
                   rx_byte[7:4] == 4'h0) begin
            d.rx_fr = 4'h0;
            d.fsm = SYNC;
          end
        end
        SYNC: if ((even0 && !fas_ok) ||
                  (q.ctrl.cas_en && q.rx_ts == `E1_TS16 &&
                   q.rx_fr == 4'h0 && rx_byte[7:4] != 4'h0))
          d.fsm = HUNT;
        default: d.fsm = HUNT;
      endcase
      // CRC-4 over each sub-multiframe, C bits taken as zero
      cb = even0 ? {1'b0, rx_byte[6:0]} : rx_byte;
      d.rx_crc = crc4(q.rx_crc, cb);
      if (even0) d.rx_cbits[~q.rx_fr[2:1]] = rx_byte[7];
      if (q.rx_fr[2:0] == 3'h7 && q.rx_ts == 5'h1f) begin
        crc_hit = q.ctrl.crc_en && q.prev_valid && q.fsm == SYNC &&
                  q.rx_cbits != q.rx_crc_prev;
        d.rx_crc_prev = d.rx_crc;
        d.rx_crc = 4'h0;
        d.prev_valid = q.fsm == SYNC;
      end
      // Route payload; TS16 passes only when CAS is off
      if (q.fsm == SYNC && q.rx_ts != 5'h00 &&
          !(q.rx_ts == `E1_TS16 && q.ctrl.cas_en)) begin
        d.rx_out.data = rx_byte;
        d.rx_out.slot = q.rx_ts;
        d.rx_out.drop_valid = rcode == SL_DROP;
        d.rx_out.dte_valid = rcode == SL_DTE;
      end
    end
    if (q.fsm != SYNC) d.prev_valid = 1'b0;
    // Hardware set wins over the software clear above
    if (crc_hit) d.crc_err = 1'b1;
    // Transmit byte builder on the selected clock
    if (tx_tick) begin
      if (q.tx_ts == 5'h00) begin
        if (!q.tx_fr[0])
          tb = {q.ctrl.crc_en ? q.tx_crc_prev[~q.tx_fr[2:1]] : 1'b1,
                `E1_FAS};
        else
          tb = {q.ctrl.crc_en ? SI_BITS[q.tx_fr] : 1'b1,
                1'b1, alarm_tx, 5'h1f};
      end else if (q.tx_ts == `E1_TS16 && q.ctrl.cas_en) begin
        if (q.tx_fr == 4'h0)
          tb = `E1_MFAS_WORD;
        else begin
          // Only the drop port carries signalling
          tb[7:4] = act[{1'b0, q.tx_fr, 1'b0} +: 2] == SL_DROP ?
                    drop_sig[7:4] : 4'hf;
          tb[3:0] = act[{1'b1, q.tx_fr, 1'b0} +: 2] == SL_DROP ?
                    drop_sig[3:0] : 4'hf;
        end
      end else begin
        unique case (tcode)
          SL_DROP: tb = drop_tx_byte;
          SL_DTE: tb = dte_tx_byte;
          default: tb = 8'hff;
        endcase
      end
      d.tx_byte = tb;
      d.tx_valid = 1'b1;
      cb = (q.tx_ts == 5'h00 && !q.tx_fr[0]) ? {1'b0, tb[6:0]} : tb;
      d.tx_crc = crc4(q.tx_crc, cb);
      if (q.tx_fr[2:0] == 3'h7 && q.tx_ts == 5'h1f) begin
        d.tx_crc_prev = d.tx_crc;
        d.tx_crc = 4'h0;
      end
      d.tx_ts = 5'(q.tx_ts + 5'h01);
      d.tx_fr = q.tx_ts == 5'h1f ? 4'(q.tx_fr + 4'h1) : q.tx_fr;
    end
    // Local oscillator divider
    d.int_cnt = int_tick ? 8'h00 : 8'(q.int_cnt + 8'h01);
    // Time of day and map exchange, checked once per second
    d.sec_cnt = sec_tick ? 32'h0 : 32'(q.sec_cnt + 32'h1);
    if (sec_tick) begin
      tod_n.sec = q.tod.sec == 6'd59 ? 6'h00 : 6'(q.tod.sec + 6'h01);
      if (q.tod.sec == 6'd59)
        tod_n.min = q.tod.min == 6'd59 ? 6'h00 : 6'(q.tod.min + 6'h01);
      if (q.tod.sec == 6'd59 && q.tod.min == 6'd59)
        tod_n.hour = q.tod.hour == 5'd23 ? 5'h00 : 5'(q.tod.hour + 5'h01);
      d.tod = tod_n;
      if (q.ctrl.xchg_en) begin
        if (tod_n == q.time_a) d.ctrl.map_sel = 1'b0;
        if (tod_n == q.time_b) d.ctrl.map_sel = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.fsm <= HUNT;
    end else begin
      q <= d;
    end
  end

  // Checks
  a_fas_only_sync: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.fsm == FAS_CHK && rx_tick && even0 && fas_ok && !q.ctrl.cas_en
    |=> frame_sync) else $error("FAS alone did not give sync");
  a_nfas_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.fsm == NFAS_CHK && rx_tick && q.rx_ts == 5'h00 && q.ctrl.nfas_en &&
    !rx_byte[6] |=> q.fsm == HUNT) else $error("bad NFAS accepted");
  a_mf_word_tx: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_tick && q.ctrl.cas_en && q.tx_ts == `E1_TS16 && q.tx_fr == 4'h0
    |=> tx_valid && tx_byte == `E1_MFAS_WORD)
    else $error("TS16 alignment word missing");
  a_idle_sig_ones: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_tick && q.ctrl.cas_en && q.tx_ts == `E1_TS16 && q.tx_fr != 4'h0 &&
    act[{1'b0, q.tx_fr, 1'b0} +: 2] != SL_DROP |=> tx_byte[7:4] == 4'hf)
    else $error("idle slot signalling not ones");
  a_ts16_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.ctrl.cas_en |=> q.map_a[33:32] == SL_IDLE &&
    q.map_b[33:32] == SL_IDLE) else $error("TS16 mapped under CAS");
  // A status clear taken with the set may legally drop the flag later
  a_crc_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    crc_hit && !(take && hwrite && haddr[11:0] == `E1_STAT_OFS)
    |=> q.crc_err [*2]) else $error("CRC error not held");
  a_far_alarm_bit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_tick && q.tx_ts == 5'h00 && q.tx_fr[0]
    |=> tx_byte[5] == $past(alarm_tx)) else $error("A bit wrong");
  a_map_switch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sec_tick && q.ctrl.xchg_en && tod_n == q.time_a && tod_n != q.time_b
    |=> !q.ctrl.map_sel) else $error("map A not taken at time");
  a_no_exchange: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !q.ctrl.xchg_en && !(q.wr_pend && q.addr == `E1_CTRL_OFS)
    |=> $stable(q.ctrl.map_sel)) else $error("map changed alone");
  a_ts16_route: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_tick && frame_sync && !q.ctrl.cas_en && q.rx_ts == `E1_TS16 &&
    rcode == SL_DTE |=> rx_out.dte_valid && rx_out.data == $past(rx_byte))
    else $error("TS16 not passed through");
  a_normal_refused: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.wr_pend && q.addr == `E1_CTRL_OFS && hwdata[6:4] == 3'h4 &&
    !sec_present |=> $stable(q.ctrl.timing))
    else $error("normal timing taken without module");
endmodule

// ==== inc/e1_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: AHB-Lite byte addresses, 32-bit aligned registers.
// Notes: Included by the E1 framing and timing block.
`ifndef E1_MAP_SVH
`define E1_MAP_SVH
// Register byte offsets
`define E1_CTRL_OFS 12'h000
`define E1_STAT_OFS 12'h004
`define E1_TOD_OFS 12'h008
`define E1_TIMEA_OFS 12'h00c
`define E1_TIMEB_OFS 12'h010
`define E1_MAPA_LO_OFS 12'h014
`define E1_MAPA_HI_OFS 12'h018
`define E1_MAPB_LO_OFS 12'h01c
`define E1_MAPB_HI_OFS 12'h020
// Control fields
`define E1_NFAS_BIT 0
`define E1_CAS_BIT 1
`define E1_CRC_BIT 2
`define E1_FARGEN_BIT 3
`define E1_TIMING_LSB 4
`define E1_XCHG_BIT 7
`define E1_MAPSEL_BIT 8
// Status fields
`define E1_SYNC_BIT 0
`define E1_CRCERR_BIT 1
`define E1_ALARM_BIT 2
`define E1_INUSE_BIT 3
// Frame words
`define E1_FAS 7'h1b
`define E1_MFAS_WORD 8'h0b
`define E1_SI_PATTERN 16'hfdbf
`define E1_TS16 5'h10
// Reset value of every register but STAT, whose alarm bit reads 1
`define E1_REG_RST 32'h0000_0000
// Timing
`define E1_CLK_NS 100
`define E1_SEC_NS 1000000000
`define E1_SEC_CYCLES (`E1_SEC_NS / `E1_CLK_NS)
`define E1_BYTE_NS 3906
`define E1_INT_DIV (`E1_BYTE_NS / `E1_CLK_NS)
`endif

// ==== inc/e1_pkg.sv ====
// Purpose: Types of the E1 framing and timing block.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Constants live in e1_map.svh.
package e1_pkg;
  typedef enum logic [4:0] {
    HUNT = 5'h01, NFAS_CHK = 5'h02, FAS_CHK = 5'h04,
    MF_HUNT = 5'h08, SYNC = 5'h10
  } frame_state_type;
  typedef enum logic [2:0] {
    TM_NET = 3'h0, TM_DROP = 3'h1, TM_DTE = 3'h2,
    TM_INT = 3'h3, TM_NORMAL = 3'h4
  } timing_type;
  typedef enum logic [1:0] {
    SL_IDLE = 2'h0, SL_TST = 2'h1, SL_DROP = 2'h2, SL_DTE = 2'h3
  } slot_type;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tod_type;
  typedef struct packed {
    logic nfas_en;
    logic cas_en;
    logic crc_en;
    logic far_gen;
    timing_type timing;
    logic xchg_en;
    logic map_sel;
  } ctrl_type;
  typedef struct packed {
    logic [7:0] data;
    logic [4:0] slot;
    logic drop_valid;
    logic dte_valid;
  } rx_out_type;
  typedef struct packed {
    ctrl_type ctrl;
    tod_type tod;
    tod_type time_a;
    tod_type time_b;
    logic [63:0] map_a;
    logic [63:0] map_b;
    logic wr_pend;
    logic [11:0] addr;
    logic [31:0] rdata;
    frame_state_type fsm;
    logic [4:0] rx_ts;
    logic [3:0] rx_fr;
    logic [3:0] rx_crc;
    logic [3:0] rx_crc_prev;
    logic [3:0] rx_cbits;
    logic prev_valid;
    logic crc_err;
    rx_out_type rx_out;
    logic [4:0] tx_ts;
    logic [3:0] tx_fr;
    logic [3:0] tx_crc;
    logic [3:0] tx_crc_prev;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic [7:0] int_cnt;
    logic [31:0] sec_cnt;
  } state_type;
endpackage

// ==== bench/e1_line_model.sv ====
// Purpose: Line and port partner of the E1 framing block.
// Assumes: One line byte every fourth cycle, ports tick freely.
// Notes: Bytes invert between ticks so stale data never matches.
`timescale 1ns/100ps
module e1_line_model (
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Async reset, low
  input wire logic en, // Line carries frames
  input wire logic bad_nfas, // Clear bit 6 of odd TS0
  input wire logic bad_mf, // Spoil TS16 alignment word
  output logic rx_tick, // Line byte strobe
  output logic [7:0] rx_byte, // Line byte
  output logic drop_clk_tick, // Drop byte clock
  output logic dte_clk_tick, // DTE byte clock
  output logic [7:0] drop_tx_byte, // Drop payload
  output logic [7:0] dte_tx_byte, // DTE payload
  output logic [7:0] drop_sig // Drop signalling nibbles
);
  logic [1:0] div_q;
  logic [4:0] slot_q;
  logic [3:0] fr_q;
  logic [2:0] dcnt_q;
  logic [2:0] ecnt_q;
  logic [7:0] nxt;
  // Fixed port data; the bench expects exactly these
  assign drop_tx_byte = 8'h3c;
  assign dte_tx_byte = 8'hc3;
  assign drop_sig = 8'h5a;
  // Frame content: FAS even, NFAS odd, TS16 alignment
  // C bits flip every eight frames, so some CRC-4 check must miss
  always_comb begin
    if (slot_q == 5'h00) begin
      nxt = fr_q[0] ? (bad_nfas ? 8'h9f : 8'hdf) : {fr_q[3], 7'h1b};
    end else if (slot_q == 5'h10) begin
      nxt = bad_mf ? 8'hff : 8'h0b;
    end else begin
      nxt = {3'h2, slot_q};
    end
  end
  // Line and port strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 2'h0;
      slot_q <= 5'h00;
      fr_q <= 4'h0;
      dcnt_q <= 3'h0;
      ecnt_q <= 3'h0;
      rx_tick <= 1'b0;
      rx_byte <= 8'h00;
      drop_clk_tick <= 1'b0;
      dte_clk_tick <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      rx_tick <= en && div_q == 2'h3;
      if (en && div_q == 2'h3) begin
        rx_byte <= nxt;
        slot_q <= slot_q + 5'h01;
        if (slot_q == 5'h1f) begin
          fr_q <= fr_q + 4'h1;
        end
      end else begin
        rx_byte <= ~rx_byte;
      end
      dcnt_q <= (dcnt_q == 3'h4) ? 3'h0 : dcnt_q + 3'h1;
      drop_clk_tick <= dcnt_q == 3'h4;
      ecnt_q <= (ecnt_q == 3'h6) ? 3'h0 : ecnt_q + 3'h1;
      dte_clk_tick <= ecnt_q == 3'h6;
    end
  end
endmodule

// ==== bench/test_e1_framing_timing_config.sv ====
// Purpose: Self-checking bench of the E1 framing and timing block.
// Assumes: Zero wait state slave; SEC_CYCLES 20, INT_DIV 4.
// Notes: Absence of sync is judged over a window of many frames.
`timescale 1ns/100ps
`include "e1_map.svh"
module test_e1_framing_timing_config;
  import e1_pkg::*;
  typedef struct {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] ex;
  } row_type;
  row_type rows [10];
  logic hclk, hresetn, hsel, hwrite, sec_present, en, bad_nfas, bad_mf;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic hreadyout, hresp, rx_tick, drop_clk_tick, dte_clk_tick, tx_tick;
  logic tx_valid, frame_sync, far_alarm, tx_chk, crc_on, pv, src;
  logic [7:0] rx_byte, drop_tx_byte, dte_tx_byte, drop_sig, tx_byte;
  logic [4:0] tx_slot, ps;
  logic [3:0] tx_frame, pf;
  rx_out_type rx_out;
  int err_count, check_count, n, m, cnt, tk;
  e1_framing_timing_config #(.SEC_CYCLES(20), .INT_DIV(8'h04)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_tick(rx_tick), .rx_byte(rx_byte),
    .drop_clk_tick(drop_clk_tick), .dte_clk_tick(dte_clk_tick),
    .sec_present(sec_present), .drop_tx_byte(drop_tx_byte),
    .dte_tx_byte(dte_tx_byte), .drop_sig(drop_sig), .tx_tick(tx_tick),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_slot(tx_slot),
    .tx_frame(tx_frame), .rx_out(rx_out), .frame_sync(frame_sync),
    .far_alarm(far_alarm));
  e1_line_model line (
    .hclk(hclk), .hresetn(hresetn), .en(en), .bad_nfas(bad_nfas),
    .bad_mf(bad_mf), .rx_tick(rx_tick), .rx_byte(rx_byte),
    .drop_clk_tick(drop_clk_tick), .dte_clk_tick(dte_clk_tick),
    .drop_tx_byte(drop_tx_byte), .dte_tx_byte(dte_tx_byte),
    .drop_sig(drop_sig));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task report_and_stop;
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; read data taken at the data phase edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin err_count++; report_and_stop(); end
  endtask
  task wait_sync(input int lim);
    m = 0;
    while (frame_sync !== 1'b1 && m < lim) begin @(posedge hclk); m++; end
    if (m >= lim) begin err_count++; report_and_stop(); end
  endtask
  task wait_use(input logic v);
    m = 0;
    do begin bus(1'b0, `E1_STAT_OFS, 0); m++; end
    while (rd[3] !== v && m < 200);
    if (m >= 200) begin err_count++; report_and_stop(); end
  endtask
  // Expected transmit byte, far alarm quiet since in sync
  function automatic logic [7:0] exp_tx(input logic [4:0] s,
                                        input logic [3:0] f);
    logic [15:0] si;
    si = `E1_SI_PATTERN;
    if (s == 5'h00) return f[0] ? {crc_on ? si[f] : 1'b1, 7'h5f}
                                : {1'b1, `E1_FAS};
    if (s == 5'h10) return f == 4'h0 ? 8'h0b : f == 4'h1 ? 8'h5f : 8'hff;
    if (s == 5'h01) return 8'h3c;
    return 8'hff;
  endfunction
  // Transmit monitor: slot and frame seen at the tick, byte one later
  always @(posedge hclk) begin
    if (tx_chk && tx_valid === 1'b1 && pv &&
        !(crc_on && ps == 5'h00 && !pf[0]))
      check(tx_byte, exp_tx(ps, pf));
    pv = tx_tick === 1'b1;
    ps = tx_slot;
    pf = tx_frame;
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
    haddr = 32'h0; hwdata = 32'h0; sec_present = 1'b0; en = 1'b0;
    bad_nfas = 1'b0; bad_mf = 1'b0; tx_chk = 1'b0; crc_on = 1'b0;
    pv = 1'b0; err_count = 0; check_count = 0;
    rows[0] = '{12'h040, 32'hffff_ffff, `E1_STAT_OFS, 32'h4};
    rows[1] = '{`E1_CTRL_OFS, 32'h40, `E1_CTRL_OFS, 32'h0};
    rows[2] = '{`E1_CTRL_OFS, 32'h130, `E1_CTRL_OFS, 32'h130};
    rows[3] = '{12'h040, 32'h0, `E1_STAT_OFS, 32'hc};
    rows[4] = '{`E1_MAPA_HI_OFS, 32'h3, `E1_MAPA_HI_OFS, 32'h3};
    rows[5] = '{`E1_CTRL_OFS, 32'h2, `E1_STAT_OFS, 32'h4};
    rows[6] = '{`E1_MAPA_HI_OFS, 32'he, `E1_TIMEA_OFS, 32'h0};
    rows[7] = '{`E1_TIMEB_OFS, 32'h1041, `E1_MAPA_HI_OFS, 32'hc};
    rows[8] = '{12'h040, 32'h0, `E1_TIMEB_OFS, 32'h1041};
    rows[9] = '{`E1_CTRL_OFS, 32'h0, 12'h040, 32'h0};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Register rows: write one place, read back the same place or another
    foreach (rows[i]) begin
      bus(1'b1, rows[i].wa, rows[i].wd);
      bus(1'b0, rows[i].ra, 0);
      check(rd, rows[i].ex);
    end
    check({hreadyout, hresp}, 2'h2);
    // Spoiled odd TS0 blocks sync only while the NFAS check is on
    bad_nfas <= 1'b1;
    en <= 1'b1;
    bus(1'b1, `E1_CTRL_OFS, 32'h1);
    repeat (3000) @(posedge hclk);
    check(frame_sync, 0);
    bus(1'b1, `E1_CTRL_OFS, 32'h0);
    wait_sync(6000);
    check(frame_sync, 1);
    // Reset in mid-run drops sync and clears control
    hresetn <= 1'b0;
    @(posedge hclk);
    check(frame_sync, 0);
    hresetn <= 1'b1;
    bad_nfas <= 1'b0;
    bad_mf <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `E1_CTRL_OFS, 0);
    check(rd, 0);
    // Without TS16 alignment no sync, and the far alarm is sent
    bus(1'b1, `E1_CTRL_OFS, 32'h0b);
    repeat (3000) @(posedge hclk);
    check(frame_sync, 0);
    check(far_alarm, 1);
    bad_mf <= 1'b0;
    wait_sync(8000);
    check(far_alarm, 0);
    // One drop slot, then CRC-4 on, over a full multiframe each
    // Monitor paused while settings change; bytes in flight use old ones
    bus(1'b1, `E1_MAPA_LO_OFS, 32'h8);
    repeat (4) @(posedge hclk);
    tx_chk <= 1'b1;
    repeat (2200) @(posedge hclk);
    tx_chk <= 1'b0;
    bus(1'b1, `E1_CTRL_OFS, 32'h0f);
    repeat (4) @(posedge hclk);
    crc_on = 1'b1;
    tx_chk <= 1'b1;
    repeat (2200) @(posedge hclk);
    tx_chk <= 1'b0;
    bus(1'b0, `E1_STAT_OFS, 0);
    check(rd[1:0], 2'h3);
    crc_on = 1'b0;
    // Each clock source in turn; receive keeps its sync
    sec_present <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, `E1_CTRL_OFS, 32'h0b | (k << 4));
      cnt = 0;
      tk = 0;
      repeat (40) begin
        @(posedge hclk);
        src = k == 1 ? drop_clk_tick : k == 2 ? dte_clk_tick : rx_tick;
        if (k != 3 && tx_tick !== src) cnt++;
        if (tx_tick === 1'b1) tk++;
      end
      check(k == 3 ? tk : cnt, k == 3 ? 10 : 0);
      check(frame_sync, 1);
    end
    // TS16 passes through to the DTE with CAS off
    bus(1'b1, `E1_CTRL_OFS, 32'h1);
    bus(1'b1, `E1_MAPA_HI_OFS, 32'h3);
    n = 0;
    while (!(rx_out.dte_valid === 1'b1 && rx_out.slot === 5'h10) &&
           n < 3000) begin @(posedge hclk); n++; end
    if (n >= 3000) begin err_count++; report_and_stop(); end
    check(rx_out.data, 8'h0b);
    n = 0;
    while (!(rx_out.drop_valid === 1'b1 && rx_out.slot === 5'h01) &&
           n < 3000) begin @(posedge hclk); n++; end
    if (n >= 3000) begin err_count++; report_and_stop(); end
    check(rx_out.data, 8'h41);
    // Time of day exchange, map A at 2 s and map B at 4 s
    bus(1'b1, `E1_TIMEA_OFS, 32'h2);
    bus(1'b1, `E1_TIMEB_OFS, 32'h4);
    bus(1'b1, `E1_CTRL_OFS, 32'h181);
    bus(1'b1, `E1_TOD_OFS, 32'h0);
    wait_use(1'b0);
    bus(1'b0, `E1_TOD_OFS, 0);
    check(rd, 32'h2);
    wait_use(1'b1);
    bus(1'b0, `E1_TOD_OFS, 0);
    check(rd, 32'h4);
    bus(1'b0, `E1_CTRL_OFS, 0);
    check(rd[8], 1'b1);
    bus(1'b1, `E1_CTRL_OFS, 32'h1);
    bus(1'b1, `E1_TOD_OFS, 32'h0);
    repeat (200) @(posedge hclk);
    bus(1'b0, `E1_STAT_OFS, 0);
    check(rd[3], 1'b0);
    report_and_stop();
  end
endmodule
